/* hw/zone_sensor_hold_and_induct_run.sv */
// zone photo-sensor hold with flicker count and induct extension of the roller motor
//
// Functional notes
// - keep motor running for induct extension after blocking
// - time mode extension 0 to 65 s, reset 0
// - distance extension 0 to 65535 mm, reset 0
// - separate extension setting for each zone
// - per zone choice of time or distance
// - hold accepted sensor state, ignore changes meanwhile
// - accept blocking edge at once, then hold
// - accept clearing edge at once, then hold
// - count ignored changes, readable for diagnostics
// - hold interval 0 to 2 s, reset 0.1 s
// - one hold interval shared by both sensors
// - distance metric counts millimetres, not seconds
module zone_sensor_hold_and_induct_run #(
  parameter int STEP_CYC = zone_pkg::STEP_CYC
) (
  input  wire  logic                          ref_clk_i,
  input  wire  logic                          resetn_i,
  input  wire  logic                          ce_i,
  input  wire  logic [zone_pkg::ADDR_W-1:0]   addr_i,
  input  wire  logic [zone_pkg::DATA_W-1:0]   wdata_i,
  input  wire  logic                          wr_i,
  input  wire  logic                          rd_i,
  output logic       [zone_pkg::DATA_W-1:0]   rdata_o,
  input  wire  logic [zone_pkg::ZONES-1:0]    sensor_i,
  input  wire  logic [zone_pkg::ZONES-1:0]    travel_pulse_i,
  input  wire  logic [zone_pkg::ZONES-1:0]    run_req_i,
  output logic       [zone_pkg::ZONES-1:0]    zone_roller_motor_o,
  output logic       [zone_pkg::ZONES-1:0]    sensor_state_o
);
  import zone_pkg::*;

  // ************
  // state record
  // ************
  // every register of the block lives in this record so that one
  // clock enable and one reset reach all of it; the sens_prev and
  // trav_prev stages give edge detection without reading a raw pin
  typedef struct packed {
    logic [1:0]       sens_s1;
    logic [1:0]       sens_s2;
    logic [1:0]       sens_prev;
    logic [1:0]       trav_s1;
    logic [1:0]       trav_s2;
    logic [1:0]       trav_prev;
    logic [1:0]       sens;
    logic [1:0][7:0]  hold;
    logic [1:0][15:0] flick;
    logic [1:0][15:0] ext;
    logic [1:0]       motor;
    logic [1:0]       metric;
    logic [1:0][15:0] ind;
    logic [7:0]       deb;
    logic [STEP_W-1:0] step_cnt;
    logic             step;
    logic [15:0]      rdata;
  } state_type;

  state_type st_ff;
  state_type nxt_st;

  // limit a value to a ceiling
  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lim);
    clamp16 = (v > lim) ? lim : v;
  endfunction

  // ******************
  // next state decode
  // ******************
  always_comb begin
    logic [15:0] load;
    load   = 16'h0000;
    nxt_st = st_ff;
    if (ce_i) begin
      // pin synchronisers, prev stage feeds edge and change checks
      // only the second and prev stages are read by logic; the first may be metastable
      nxt_st.sens_s1   = sensor_i;
      nxt_st.sens_s2   = st_ff.sens_s1;
      nxt_st.sens_prev = st_ff.sens_s2;
      nxt_st.trav_s1   = travel_pulse_i;
      nxt_st.trav_s2   = st_ff.trav_s1;
      nxt_st.trav_prev = st_ff.trav_s2;
      // one-cycle strobe per step; every time setting counts these strobes
      // 10 ms step base
      if (st_ff.step_cnt == STEP_W'(STEP_CYC - 1)) begin
        nxt_st.step_cnt = '0;
        nxt_st.step     = 1'b1;
      end else begin
        nxt_st.step_cnt = st_ff.step_cnt + STEP_W'(1);
        nxt_st.step     = 1'b0;
      end
      // register writes
      // writes to unmapped offsets and to the status word are ignored
      if (wr_i) begin
        case (addr_i)
          A_CTRL:  nxt_st.metric = wdata_i[1:0];
          A_IND0:  nxt_st.ind[0] = wdata_i;
          A_IND1:  nxt_st.ind[1] = wdata_i;
          A_DEB:   nxt_st.deb = 8'(clamp16(wdata_i, {8'h00, DEB_MAX}));
          A_FLK0:  nxt_st.flick[0] = 16'h0000;
          A_FLK1:  nxt_st.flick[1] = 16'h0000;
          default: nxt_st.metric = st_ff.metric;
        endcase
      end
      // the hold is not a delay before detection: an edge is taken in the
      // cycle it leaves the synchroniser and the hold starts only then, so a
      // short flicker right after an arrival cannot hide the arrival itself
      for (int z = 0; z < ZONES; z++) begin
        if (st_ff.hold[z] == 8'h00) begin
          if (st_ff.sens_s2[z] != st_ff.sens[z]) begin
            nxt_st.sens[z] = st_ff.sens_s2[z];
            nxt_st.hold[z] = st_ff.deb;
            // an item that blocks the sensor without a run request was not
            // received from upstream, so it gets no extension
            // blocking while receiving starts extension
            if (st_ff.sens_s2[z] && run_req_i[z]) begin
              load = st_ff.metric[z] ? clamp16(st_ff.ind[z], IND_DIST_MAX)
                                     : clamp16(st_ff.ind[z], IND_TIME_MAX);
              nxt_st.ext[z] = load;
            end
          end
        end else begin
          if (st_ff.step)
            nxt_st.hold[z] = st_ff.hold[z] - 8'h01;
          // the count saturates rather than wraps so a noisy sensor is never
          // reported as a quiet one
          // saturating flicker count, an event in a clear cycle counts from zero
          if (st_ff.sens_s2[z] != st_ff.sens_prev[z] && nxt_st.flick[z] != 16'hFFFF)
            nxt_st.flick[z] = nxt_st.flick[z] + 16'h0001;
        end
        // distance counts travel pulses, time counts steps
        if (st_ff.ext[z] != 16'h0000 && nxt_st.ext[z] == st_ff.ext[z]) begin
          if (st_ff.metric[z] ? (st_ff.trav_s2[z] && !st_ff.trav_prev[z]) : st_ff.step)
            nxt_st.ext[z] = st_ff.ext[z] - 16'h0001;
        end
        // motor runs on request or pending extension
        nxt_st.motor[z] = run_req_i[z] | (nxt_st.ext[z] != 16'h0000);
      end
      // reads return zero outside their one cycle so a stale word is never
      // mistaken for a fresh one
      // read data valid only in the cycle after the strobe
      nxt_st.rdata = 16'h0000;
      if (rd_i) begin
        case (addr_i)
          A_CTRL:  nxt_st.rdata = {14'h0000, st_ff.metric};
          A_IND0:  nxt_st.rdata = st_ff.ind[0];
          A_IND1:  nxt_st.rdata = st_ff.ind[1];
          A_DEB:   nxt_st.rdata = {8'h00, st_ff.deb};
          A_STAT:  nxt_st.rdata = {12'h000, st_ff.motor, st_ff.sens};
          A_FLK0:  nxt_st.rdata = st_ff.flick[0];
          A_FLK1:  nxt_st.rdata = st_ff.flick[1];
          default: nxt_st.rdata = 16'h0000;
        endcase
      end
    end
  end

  // *************
  // state register
  // *************
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    // reset loads constants only; the hold interval comes up at its
    // default so sensors are filtered from the first cycle
    if (!resetn_i) begin
      st_ff        <= '0;
      st_ff.deb    <= DEB_RST;
      st_ff.ind[0] <= IND_RST;
      st_ff.ind[1] <= IND_RST;
      st_ff.metric <= METRIC_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the record
  assign rdata_o             = st_ff.rdata;
  assign zone_roller_motor_o = st_ff.motor;
  assign sensor_state_o      = st_ff.sens;

  // **********
  // assertions
  // **********
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  // properties watch the state record; the clock enable is part of each
  // antecedent where a frozen cycle would otherwise look like a miss

  a_edge_taken_now: assert property (ce_i && st_ff.hold[0] == 8'h00 && st_ff.sens_s2[0] != st_ff.sens[0]
      |=> st_ff.sens[0] == $past(st_ff.sens_s2[0]) && st_ff.hold[0] == $past(st_ff.deb))
    else $error("left edge not taken at once");
  a_clear_taken_now: assert property (ce_i && st_ff.hold[1] == 8'h00 && st_ff.sens[1] && !st_ff.sens_s2[1]
      |=> !st_ff.sens[1])
    else $error("right clear not taken at once");
  a_hold_stable: assert property (st_ff.hold[0] != 8'h00 |=> $stable(st_ff.sens[0]))
    else $error("sensor state moved during hold");
  a_flicker_count: assert property (ce_i && st_ff.hold[1] != 8'h00 && !wr_i
      && st_ff.sens_s2[1] != st_ff.sens_prev[1] && st_ff.flick[1] != 16'hFFFF
      |=> st_ff.flick[1] == $past(st_ff.flick[1]) + 16'h0001)
    else $error("flicker not counted");
  a_motor_extends: assert property (st_ff.ext[0] != 16'h0000 |-> st_ff.motor[0])
    else $error("motor stopped during extension");
  a_time_range: assert property (ce_i && st_ff.hold[1] == 8'h00 && st_ff.sens_s2[1] && !st_ff.sens[1]
      && run_req_i[1] && !st_ff.metric[1] |=> st_ff.ext[1] <= IND_TIME_MAX)
    else $error("time extension above ceiling");
  a_deb_range: assert property (st_ff.deb <= DEB_MAX)
    else $error("hold interval above ceiling");
  // writes to zone 1 leave zone 0
  a_zone_separate: assert property (ce_i && wr_i && addr_i == A_IND1 |=> $stable(st_ff.ind[0]) ##0 st_ff.ind[1] == $past(wdata_i))
    else $error("zone settings not separate");
  a_metric_write: assert property (ce_i && wr_i && addr_i == A_CTRL |=> st_ff.metric == $past(wdata_i[1:0]))
    else $error("metric select lost");
  // distance decrements on travel edge only
  a_dist_step: assert property (ce_i && st_ff.metric[0] && st_ff.ext[0] != 16'h0000 && !st_ff.trav_s2[0]
      && st_ff.hold[0] != 8'h00 |=> st_ff.ext[0] == $past(st_ff.ext[0]))
    else $error("distance run down without travel");
  a_step_period: assert property (st_ff.step && ce_i |-> ##1 !st_ff.step)
    else $error("step base too fast");

  // ****************
  // mirror and further checks
  // ****************
  // right edge taken next cycle
  a_edge_right_taken: assert property (ce_i && st_ff.hold[1] == 8'h00 && st_ff.sens_s2[1] != st_ff.sens[1]
      |=> st_ff.sens[1] == $past(st_ff.sens_s2[1]))
    else $error("right edge not taken at once");
  a_clear_left_taken: assert property (ce_i && st_ff.hold[0] == 8'h00 && st_ff.sens[0] && !st_ff.sens_s2[0]
      |=> !st_ff.sens[0])
    else $error("left clear not taken at once");
  a_hold_right_stable: assert property (st_ff.hold[1] != 8'h00
      |=> $stable(st_ff.sens[1]))
    else $error("right sensor state moved during hold");
  // hold runs down one per step
  a_hold_count_down: assert property (ce_i && st_ff.hold[0] != 8'h00 && st_ff.step
      |=> st_ff.hold[0] == $past(st_ff.hold[0]) - 8'h01)
    else $error("hold did not run down");
  a_flicker_left: assert property (ce_i && st_ff.hold[0] != 8'h00 && !wr_i
      && st_ff.sens_s2[0] != st_ff.sens_prev[0] && st_ff.flick[0] != 16'hFFFF
      |=> st_ff.flick[0] == $past(st_ff.flick[0]) + 16'h0001)
    else $error("left flicker not counted");
  a_flicker_clear: assert property (ce_i && wr_i && addr_i == A_FLK0
      && (st_ff.hold[0] == 8'h00 || st_ff.sens_s2[0] == st_ff.sens_prev[0]) |=> st_ff.flick[0] == 16'h0000)
    else $error("flicker count not cleared");
  // read word stands one cycle only
  a_read_idle_zero: assert property (ce_i && !rd_i
      |=> st_ff.rdata == 16'h0000)
    else $error("read data outside its cycle");
  a_motor_right_extends: assert property (st_ff.ext[1] != 16'h0000
      |-> st_ff.motor[1])
    else $error("right motor stopped during extension");
  // motor stops without request or extension
  a_motor_stops: assert property (ce_i && st_ff.ext[0] == 16'h0000 && !run_req_i[0] && st_ff.hold[0] != 8'h00
      |=> !st_ff.motor[0])
    else $error("motor ran without cause");
  a_time_range_left: assert property (ce_i && st_ff.hold[0] == 8'h00 && st_ff.sens_s2[0] && !st_ff.sens[0]
      && run_req_i[0] && !st_ff.metric[0] |=> st_ff.ext[0] <= IND_TIME_MAX)
    else $error("left time extension above ceiling");
  a_dist_load: assert property (ce_i && st_ff.hold[1] == 8'h00 && st_ff.sens_s2[1] && !st_ff.sens[1]
      && run_req_i[1] && st_ff.metric[1] |=> st_ff.ext[1] == $past(st_ff.ind[1]))
    else $error("distance extension not loaded");
  // writes to zone 0 leave zone 1
  a_zone_left_separate: assert property (ce_i && wr_i && addr_i == A_IND0
      |=> $stable(st_ff.ind[1]) && st_ff.ind[0] == $past(wdata_i))
    else $error("left zone setting not separate");
  a_deb_write: assert property (ce_i && wr_i && addr_i == A_DEB
      |=> st_ff.deb == (($past(wdata_i) > {8'h00, DEB_MAX}) ? DEB_MAX : $past(wdata_i[7:0])))
    else $error("hold interval write wrong");
  a_hold_shared: assert property (ce_i && st_ff.hold[1] == 8'h00 && st_ff.sens_s2[1] != st_ff.sens[1]
      |=> st_ff.hold[1] == $past(st_ff.deb))
    else $error("right hold not from shared setting");
  a_time_on_step: assert property (ce_i && !st_ff.metric[0] && st_ff.ext[0] != 16'h0000 && !st_ff.step
      && st_ff.hold[0] != 8'h00 |=> st_ff.ext[0] == $past(st_ff.ext[0]))
    else $error("time run down between steps");
  // no step strobe before the count ends
  a_step_count: assert property (ce_i && st_ff.step_cnt != STEP_W'(STEP_CYC - 1)
      |=> !st_ff.step)
    else $error("step strobe early");
endmodule

/* hw/zone_pkg.sv */
// constants for the zone sensor hold and induct extension block
package zone_pkg;
  // ************
  // bus geometry
  // ************
  localparam int          ADDR_W   = 3;
  localparam int          DATA_W   = 16;
  localparam int          ZONES    = 2;    // index 0 upstream / left, 1 downstream / right
  // *****************
  // register offsets
  // *****************
  localparam logic [2:0]  A_CTRL   = 3'h0; // bit z: 1 = distance metric for zone z
  localparam logic [2:0]  A_IND0   = 3'h1; // upstream induct extension
  localparam logic [2:0]  A_IND1   = 3'h2; // downstream induct extension
  localparam logic [2:0]  A_DEB    = 3'h3; // shared hold interval, 10 ms steps
  localparam logic [2:0]  A_STAT   = 3'h4; // {motor[1:0], sensor[1:0]}
  localparam logic [2:0]  A_FLK0   = 3'h5; // left flicker count, write clears
  localparam logic [2:0]  A_FLK1   = 3'h6; // right flicker count, write clears
  // ****************
  // field positions
  // ****************
  localparam int          STAT_SENS_LSB  = 0;
  localparam int          STAT_MOTOR_LSB = 2;
  // *****************
  // timing constants
  // *****************
  localparam int          CLK_PERIOD_NS  = 100;
  localparam int          STEP_MS        = 10;
  localparam int          STEP_CYC       = STEP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int          STEP_W         = 17;
  localparam int          IND_TIME_MAX_S = 65;
  localparam logic [15:0] IND_TIME_MAX   = 16'(IND_TIME_MAX_S * 1000 / STEP_MS);
  localparam logic [15:0] IND_DIST_MAX   = 16'hFFFF;  // millimetres
  localparam int          DEB_MAX_S      = 2;
  localparam logic [7:0]  DEB_MAX        = 8'(DEB_MAX_S * 1000 / STEP_MS);
  localparam int          DEB_RST_MS     = 100;
  // ************
  // reset values
  // ************
  localparam logic [7:0]  DEB_RST        = 8'(DEB_RST_MS / STEP_MS);
  localparam logic [15:0] IND_RST        = 16'h0000;
  localparam logic [1:0]  METRIC_RST     = 2'h0;
endpackage

/* testbench/zone_field_model.sv */
// field model: zone photo-sensors and roller drive travel pulses
module zone_field_model (
  input  wire logic       ref_clk_i,
  input  wire logic [1:0] item_i,
  input  wire logic [1:0] motor_i,
  output logic      [1:0] sensor_o,
  output logic      [1:0] travel_pulse_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  // defined pins from time zero
  initial begin
    sensor_o = 2'h0;
    travel_pulse_o = 2'h0;
  end
  // sensor is blocked while an item sits over it
  always @(posedge ref_clk_i) sensor_o <= item_i;
  // slow pulses only while motor runs
  always @(posedge ref_clk_i) begin
    cnt <= (cnt == 39) ? 0 : cnt + 1;
    travel_pulse_o <= (cnt < 2) ? motor_i : 2'h0;
  end
endmodule

/* testbench/test_zone_sensor_hold_and_induct_run.sv */
// self-checking bench for the zone sensor hold and induct extension block
module test_zone_sensor_hold_and_induct_run;
  timeunit 1ns;
  timeprecision 1ns;
  import zone_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        resetn_i  = 1'b0;
  logic        wr_i      = 1'b0;
  logic        rd_i      = 1'b0;
  logic [2:0]  addr_i    = 3'h0;
  logic [15:0] wdata_i   = 16'h0000;
  logic [15:0] rdata_o;
  logic [1:0]  item      = 2'h0;
  logic [1:0]  run_req   = 2'h0;
  logic [1:0]  sensor, pulse, motor, state;
  int          n_mismatch  = 0;
  int          checks_done = 0;

  always #50 ref_clk_i = ~ref_clk_i;

  zone_sensor_hold_and_induct_run #(.STEP_CYC(10)) dut (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ce_i(1'b1), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .sensor_i(sensor), .travel_pulse_i(pulse), .run_req_i(run_req),
    .zone_roller_motor_o(motor), .sensor_state_o(state));

  zone_field_model field (.ref_clk_i(ref_clk_i), .item_i(item), .motor_i(motor),
    .sensor_o(sensor), .travel_pulse_o(pulse));

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [15:0] exp, input string nm);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 chk(nm, exp, rdata_o);
  endtask

  // item arrives on zone z with run request, then checks the at-once acceptance
  task automatic arrive(input int z);
    @(posedge ref_clk_i);
    run_req[z] <= 1'b1;
    item[z] <= 1'b1;
    cyc(4);
    #1 chk("state", 16'h0001, {15'h0, state[z]});
    @(posedge ref_clk_i);
    run_req[z] <= 1'b0;
  endtask

  // watchdog well beyond the expected run of about 440 cycles
  initial begin
    #1000000;
    n_mismatch++;
    results();
  end

  // main sequence
  initial begin
    cyc(16);
    resetn_i <= 1'b1;
    rd(A_DEB, 16'(DEB_RST), "deb");
    rd(A_IND0, IND_RST, "ind0");
    rd(A_IND1, IND_RST, "ind1");
    rd(A_CTRL, 16'h0000, "ctrl");
    wr(A_IND0, 16'h0003);
    wr(A_IND1, 16'h0005);
    wr(A_DEB, 16'h00FF);
    rd(A_DEB, 16'(DEB_MAX), "deb clamp");
    wr(A_DEB, 16'h0002);
    rd(A_IND0, 16'h0003, "ind0");
    rd(A_IND1, 16'h0005, "ind1");
    rd(3'h7, 16'h0000, "unmapped");
    // time mode: flicker inside the hold, motor runs three steps
    arrive(0);
    for (int i = 0; i < 4; i++) begin
      item[0] <= ~item[0];
      cyc(2);
    end
    cyc(4);
    #1 chk("motor0", 16'h0001, {15'h0, motor[0]});
    cyc(50);
    #1 chk("motor0", 16'h0000, {15'h0, motor[0]});
    chk("state0", 16'h0001, {15'h0, state[0]});
    rd(A_STAT, 16'h0001, "stat");
    rd(A_FLK0, 16'h0004, "flk0");
    wr(A_FLK0, 16'h0000);
    rd(A_FLK0, 16'h0000, "flk0");
    item[0] <= 1'b0;
    cyc(4);
    #1 chk("state0", 16'h0000, {15'h0, state[0]});
    // distance mode on zone 1: stop only after five travel pulses
    wr(A_CTRL, 16'h0002);
    rd(A_CTRL, 16'h0002, "ctrl");
    arrive(1);
    item[1] <= 1'b0;
    cyc(2);
    item[1] <= 1'b1;
    cyc(100);
    #1 chk("motor1", 16'h0001, {15'h0, motor[1]});
    cyc(200);
    #1 chk("motor1", 16'h0000, {15'h0, motor[1]});
    rd(A_STAT, 16'h0002, "stat");
    rd(A_FLK1, 16'h0002, "flk1");
    results();
  end
endmodule
